// *** design/rmrs_map.svh ***
// Purpose: offsets, field positions, reset values and counts
// Assumes: 32-bit Wishbone data, byte addresses
// Notes:   counts are in channel clock cycles
`ifndef RMRS_MAP_SVH
`define RMRS_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RMRS_OFS_TIMING   8'h00
`define RMRS_OFS_SWAP     8'h04
`define RMRS_OFS_STATUS   8'h08
// ----------------------------------------------------------------
// Field layout of row_timing_config
// ----------------------------------------------------------------
`define RMRS_TIM_PRE_LSB  0
`define RMRS_TIM_SEN_LSB  8
`define RMRS_TIM_IMP_LSB  16
`define RMRS_TIM_EXP_LSB  24
`define RMRS_TIM_MASK     32'h1F1F1F1F
`define RMRS_TIM_RST      32'h040A0701
`define RMRS_SWAP_RST     9'h000
// ----------------------------------------------------------------
// Timing counts and address layout
// ----------------------------------------------------------------
`define RMRS_OVH_CYC      11'h006
`define RMRS_CORE_FIX     11'h004
`define RMRS_REFR_ROWS    11'h004
`define RMRS_BANK_BIT     11
`define RMRS_ROW_HI       35
`define RMRS_ROW_LO       20
`endif

// *** design/rmrs_pkg.sv ***
// Purpose: shared types of the row fetch and address swap block
// Assumes: nothing beyond the map header
// Notes:   request and answer travel as packed structs
package rmrs_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_WAIT = 3'h1,
        S_OVH  = 3'h2,
        S_EXP  = 3'h3,
        S_PRE  = 3'h4,
        S_SEN  = 3'h5,
        S_REFR = 3'h6
    } rmrs_state_e;

    typedef enum logic [1:0] {
        K_READ  = 2'h0,
        K_WRITE = 2'h1,
        K_REFR  = 2'h2
    } rmrs_kind_e;

    typedef logic [35:3] rmrs_adr_t;
    typedef logic [15:0] rmrs_row_t;

    typedef struct packed {
        logic       valid;
        rmrs_kind_e kind;
        logic       close;
        rmrs_adr_t  addr;
    } rmrs_req_s;

    typedef struct packed {
        logic valid;
        logic okay;
        logic xfer;
    } rmrs_ack_s;
endpackage

// *** design/rmrs_addr_swap.sv ***
// Purpose: bitwise exchange of the two nine-bit address fields
// Assumes: purely combinational, one select bit per bit pair
// Notes:   select all ones swaps the fields completely
module rmrs_addr_swap (
    input  rmrs_pkg::rmrs_adr_t  addr,
    input  wire logic [8:0]      sel,
    output rmrs_pkg::rmrs_adr_t  mapped
);
    import rmrs_pkg::*;

    // ------------------------------------------------------------
    // Pass-through fields
    // ------------------------------------------------------------
    assign mapped[35:29] = addr[35:29];
    assign mapped[10:3]  = addr[10:3];

    // ------------------------------------------------------------
    // Per-pair routing
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 9; i++) begin : g_pair
            // Straight or crossed per pair
            assign mapped[20 + i] = sel[i] ? addr[11 + i]
                                           : addr[20 + i];
            assign mapped[11 + i] = sel[i] ? addr[20 + i]
                                           : addr[11 + i];
        end
    endgenerate
endmodule

// *** design/rmrs_top.sv ***
// Purpose: row cache retry logic of a packet-channel memory
// Assumes: channel signals come from the link clock domain
// Notes:   intervals count synchronised link clock edges
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`include "rmrs_map.svh"
module rmrs_top #(
    parameter int NBANK = 2
) (
    input  wire logic            clk_sys,
    input  wire logic            resetn,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    input  wire logic            link_clk,
    input  rmrs_pkg::rmrs_req_s  chan_req,
    output rmrs_pkg::rmrs_ack_s  chan_ack,
    output rmrs_pkg::rmrs_adr_t  mapped_address
);
    import rmrs_pkg::*;

    localparam int BW = (NBANK > 1) ? $clog2(NBANK) : 1;

    // ------------------------------------------------------------
    // Link synchronisers
    // ------------------------------------------------------------
    logic [2:0]  lclk_sh, next_lclk_sh;
    logic        lnk_lvl, next_lnk_lvl;
    rmrs_req_s   req_s1, req_s2, req_s3;
    logic        agree, tick, take;

    always_comb begin
        next_lclk_sh = {lclk_sh[1:0], link_clk};
        agree        = (lclk_sh[1] == lclk_sh[2]);
        next_lnk_lvl = agree ? lclk_sh[2] : lnk_lvl;
        // Edge counts only once stages two and three agree
        tick         = agree && lclk_sh[2] && !lnk_lvl;
        take         = tick && req_s3.valid;
    end

    // Request rides the same three stages so it lines up with tick
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lclk_sh <= 3'h0;
            lnk_lvl <= 1'b0;
            req_s1  <= '0;
            req_s2  <= '0;
            req_s3  <= '0;
        end else begin
            lclk_sh <= next_lclk_sh;
            lnk_lvl <= next_lnk_lvl;
            req_s1  <= chan_req;
            req_s2  <= req_s1;
            req_s3  <= req_s2;
        end
    end

    // ------------------------------------------------------------
    // Wishbone registers
    // ------------------------------------------------------------
    logic [31:0] tim, next_tim;
    logic [8:0]  swap_sel, next_swap_sel;
    logic [31:0] next_dat;
    logic        next_ack;
    logic [31:0] status;

    function automatic logic [1:0] reg_dec(input logic [7:0] a);
        case (a)
            `RMRS_OFS_TIMING: reg_dec = 2'h1;
            `RMRS_OFS_SWAP:   reg_dec = 2'h2;
            `RMRS_OFS_STATUS: reg_dec = 2'h3;
            default:          reg_dec = 2'h0;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0] sw;
        sw            = {23'h0, swap_sel};
        next_tim      = tim;
        next_swap_sel = swap_sel;
        next_ack      = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat      = 32'h00000000;
        // Writes land on the edge where the master sees ack
        if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
            case (reg_dec(wb_adr_i))
                2'h1: next_tim = merge(tim, wb_dat_i, wb_sel_i)
                                 & `RMRS_TIM_MASK;
                2'h2: next_swap_sel = 9'(merge(sw, wb_dat_i,
                                               wb_sel_i));
                default: next_tim = tim;
            endcase
        end
        if (next_ack) begin
            case (reg_dec(wb_adr_i))
                2'h1:    next_dat = tim;
                2'h2:    next_dat = sw;
                2'h3:    next_dat = status;
                default: next_dat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tim      <= `RMRS_TIM_RST;
            swap_sel <= `RMRS_SWAP_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            tim      <= next_tim;
            swap_sel <= next_swap_sel;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ------------------------------------------------------------
    // Address mapping and interval lengths
    // ------------------------------------------------------------
    rmrs_adr_t   map_adr;
    logic [BW-1:0] bank;
    rmrs_row_t   row;
    logic [10:0] t_pre, t_sen, t_imp, t_exp, hold_tot;

    rmrs_addr_swap u_swap (
        .addr   (req_s3.addr),
        .sel    (swap_sel),
        .mapped (map_adr)
    );

    function automatic logic [10:0] core(input logic [4:0] v);
        return `RMRS_CORE_FIX + {6'h00, v};
    endfunction

    // ------------------------------------------------------------
    // Bank flags and row fetch machine
    // ------------------------------------------------------------
    rmrs_state_e         st, next_st;
    logic [10:0]         cnt, next_cnt;
    logic [5:0]          imp_cnt, next_imp_cnt;
    logic [NBANK-1:0]    vld, next_vld, dirty, next_dirty;
    rmrs_row_t           row_q [NBANK];
    rmrs_row_t           next_row_q [NBANK];
    logic [BW-1:0]       tgt_bank, next_tgt_bank;
    rmrs_row_t           tgt_row, next_tgt_row;
    logic                hit, fin;

    always_comb begin
        bank  = map_adr[`RMRS_BANK_BIT +: BW];
        row   = map_adr[`RMRS_ROW_HI:`RMRS_ROW_LO];
        t_pre = core(tim[`RMRS_TIM_PRE_LSB +: 5]);
        t_sen = core(tim[`RMRS_TIM_SEN_LSB +: 5]);
        t_imp = core(tim[`RMRS_TIM_IMP_LSB +: 5]);
        t_exp = core(tim[`RMRS_TIM_EXP_LSB +: 5]);
        // Open-row term plus four refresh-row terms
        hold_tot = `RMRS_OVH_CYC + (dirty[bank] ? t_exp : 11'h000)
                 + (t_pre << 1) + t_sen
                 + `RMRS_REFR_ROWS * (`RMRS_OVH_CYC + t_imp
                                      + (t_pre << 1) + t_sen);
        hit    = vld[bank] && (row_q[bank] == row);
        status = {27'h0, (imp_cnt != 6'h00),
                  (st == S_REFR), st};
    end

    always_comb begin
        next_st       = st;
        next_cnt      = cnt;
        next_vld      = vld;
        next_dirty    = dirty;
        next_row_q    = row_q;
        next_tgt_bank = tgt_bank;
        next_tgt_row  = tgt_row;
        next_imp_cnt  = imp_cnt;
        // Every interval advances on channel clock edges
        fin = tick && (cnt == 11'h001);
        if (tick && (imp_cnt != 6'h00)) begin
            next_imp_cnt = imp_cnt - 6'h01;
        end
        if (tick && (cnt > 11'h001)) begin
            next_cnt = cnt - 11'h001;
        end
        case (st)
            S_IDLE: begin
                if (take && (req_s3.kind == K_REFR)) begin
                    next_st       = S_REFR;
                    next_cnt      = hold_tot;
                    next_tgt_bank = bank;
                end else if (take && !hit) begin
                    next_st       = S_WAIT;
                    next_tgt_bank = bank;
                    next_tgt_row  = row;
                end else if (take) begin
                    if (req_s3.kind == K_WRITE) begin
                        next_dirty[bank] = 1'b1;
                    end
                    if (req_s3.close) begin
                        // Close restores now, so no later write-back
                        next_dirty[bank] = 1'b0;
                        next_imp_cnt     = t_exp[5:0];
                    end
                end
            end
            S_WAIT: begin
                // A pending restore stretches this retry
                if (imp_cnt == 6'h00) begin
                    next_st  = S_OVH;
                    next_cnt = `RMRS_OVH_CYC;
                end
            end
            S_OVH: begin
                if (fin && dirty[tgt_bank]) begin
                    next_st  = S_EXP;
                    next_cnt = t_exp;
                end else if (fin) begin
                    next_st  = S_PRE;
                    next_cnt = t_pre;
                end
            end
            S_EXP: begin
                if (fin) begin
                    next_dirty[tgt_bank] = 1'b0;
                    next_st              = S_PRE;
                    next_cnt             = t_pre;
                end
            end
            S_PRE: begin
                if (fin) begin
                    next_st  = S_SEN;
                    next_cnt = t_sen;
                end
            end
            S_SEN: begin
                if (fin) begin
                    next_row_q[tgt_bank] = tgt_row;
                    next_vld[tgt_bank]   = 1'b1;
                    next_dirty[tgt_bank] = 1'b0;
                    next_imp_cnt         = t_imp[5:0];
                    next_st              = S_IDLE;
                end
            end
            S_REFR: begin
                if (fin) begin
                    // Cache kept, only the dirty mark goes
                    next_dirty[tgt_bank] = 1'b0;
                    next_st              = S_IDLE;
                end
            end
            default: begin
                next_st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st       <= S_IDLE;
            cnt      <= 11'h000;
            imp_cnt  <= 6'h00;
            vld      <= '0;
            dirty    <= '0;
            tgt_bank <= '0;
            tgt_row  <= 16'h0000;
            for (int b = 0; b < NBANK; b++) begin
                row_q[b] <= 16'h0000;
            end
        end else begin
            st       <= next_st;
            cnt      <= next_cnt;
            imp_cnt  <= next_imp_cnt;
            vld      <= next_vld;
            dirty    <= next_dirty;
            tgt_bank <= next_tgt_bank;
            tgt_row  <= next_tgt_row;
            row_q    <= next_row_q;
        end
    end

    // ------------------------------------------------------------
    // Acknowledge window
    // ------------------------------------------------------------
    rmrs_ack_s next_chan_ack;
    rmrs_adr_t next_mapped;

    always_comb begin
        next_chan_ack = chan_ack;
        next_mapped   = mapped_address;
        if (take) begin
            next_chan_ack.valid = 1'b1;
            // Busy refuses everything and keeps nothing
            next_chan_ack.okay  = (st == S_IDLE)
                                && ((req_s3.kind == K_REFR) || hit);
            next_chan_ack.xfer  = next_chan_ack.okay
                                && (req_s3.kind != K_REFR);
            next_mapped         = map_adr;
        end else if (tick) begin
            // Window closes at the next channel edge
            next_chan_ack = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_ack       <= '0;
            mapped_address <= '0;
        end else begin
            chan_ack       <= next_chan_ack;
            mapped_address <= next_mapped;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence busy_take;
        take && (st != S_IDLE);
    endsequence

    sequence fetch_end;
        (st == S_SEN) && fin;
    endsequence

    AST_NACK_NO_DATA: assert property (
        chan_ack.valid && !chan_ack.okay |-> !chan_ack.xfer)
        else $error("refused answer carries data");

    AST_BUSY_REFUSE: assert property (
        busy_take |=> chan_ack.valid && !chan_ack.okay)
        else $error("request accepted while busy");

    AST_MISS_REFUSE: assert property (
        take && (st == S_IDLE) && !hit && (req_s3.kind != K_REFR)
        |=> !chan_ack.okay ##0 (st == S_WAIT))
        else $error("miss not refused or fetch not started");

    AST_FETCH_LOADS: assert property (
        fetch_end |=> vld[$past(tgt_bank)] && (st == S_IDLE)
                      && (imp_cnt == $past(t_imp[5:0])))
        else $error("fetch end did not load row");

    AST_WRITE_DIRTY: assert property (
        take && (st == S_IDLE) && hit && !req_s3.close
        && (req_s3.kind == K_WRITE) |=> dirty[$past(bank)])
        else $error("write hit did not mark dirty");

    AST_CLOSE_CLEAN: assert property (
        take && (st == S_IDLE) && hit && req_s3.close
        && (req_s3.kind != K_REFR) |=> !dirty[$past(bank)])
        else $error("close did not clear dirty");

    AST_OVH_LEN: assert property (
        (st == S_OVH) && ($past(st) == S_WAIT)
        |-> cnt == `RMRS_OVH_CYC)
        else $error("overhead count not six");

    AST_REFR_LOAD: assert property (
        take && (st == S_IDLE) && (req_s3.kind == K_REFR)
        |=> (st == S_REFR) && (cnt == $past(hold_tot)))
        else $error("holdoff length wrong");

    AST_REFR_CLEAN: assert property (
        (st == S_REFR) && fin |=> !dirty[$past(tgt_bank)]
        && (st == S_IDLE) && (vld == $past(vld)))
        else $error("refresh changed cache or kept dirty");

    AST_PASS_BITS: assert property (
        (map_adr[35:29] == req_s3.addr[35:29])
        && (map_adr[10:3] == req_s3.addr[10:3]))
        else $error("pass-through bits altered");

    AST_SWAP_ALL: assert property (
        (swap_sel == 9'h1FF) |-> (map_adr[28:20] == req_s3.addr[19:11])
        && (map_adr[19:11] == req_s3.addr[28:20]))
        else $error("full swap not exchanged");

    AST_WB_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
endmodule

// *** test/rmrs_initiator.sv ***
// Purpose: channel initiator model facing the row fetch block
// Assumes: free-running channel clock, 200 ns period
// Notes:   a released request shows the inverted address
module rmrs_initiator (
    output logic                link_clk,
    output rmrs_pkg::rmrs_req_s chan_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import rmrs_pkg::*;

    initial link_clk = 1'b0;
    always #100 link_clk = ~link_clk;
    initial chan_req = '0;

    // ----------------------------------------------------------
    // One request per call, then an idle cycle so answers part
    // ----------------------------------------------------------
    task automatic send(input rmrs_kind_e k, input logic c,
                        input rmrs_adr_t a);
        @(posedge link_clk);
        chan_req <= '{1'b1, k, c, a};
        @(posedge link_clk);
        chan_req <= '{1'b0, k, c, ~a};
        @(posedge link_clk);
    endtask
endmodule

// *** test/tb.sv ***
// Purpose: self-checking bench of the row fetch and swap block
// Assumes: all four core fields programmed to zero
// Notes:   expectations queued by the driver, popped by a monitor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rmrs_pkg::*;
    typedef struct packed {
        logic      okay;
        logic      xfer;
        rmrs_adr_t map;
    } rmrs_exp_s;

    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        link_clk;
    rmrs_req_s   chan_req;
    rmrs_ack_s   chan_ack;
    rmrs_adr_t   mapped_address;
    int          failures = 0;
    int          n_compared = 0;
    int          seed = 32'h5f00b9ac;
    logic        ack_seen = 1'b0;
    logic [8:0]  swap = 9'h000;
    rmrs_exp_s   ack_q[$];
    logic [31:0] wb_q[$];
    rmrs_adr_t   ra, rb, rx;

    always #12.5 clk_sys = ~clk_sys;

    rmrs_top #(.NBANK(2)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk(link_clk),
        .chan_req(chan_req), .chan_ack(chan_ack),
        .mapped_address(mapped_address));
    rmrs_initiator i_init (.link_clk(link_clk), .chan_req(chan_req));

    // ----------------------------------------------------------
    // Reference swap, one select bit per bit pair
    // ----------------------------------------------------------
    function automatic rmrs_adr_t exp_map(rmrs_adr_t a, logic [8:0] s);
        rmrs_adr_t m;
        m = a;
        for (int i = 0; i < 9; i++) begin
            if (s[i]) begin
                m[20+i] = a[11+i];
                m[11+i] = a[20+i];
            end
        end
        return m;
    endfunction

    task automatic wb_cycle(input logic we, input logic [7:0] a,
                            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (we && a == 8'h04) swap = d[8:0];
        @(posedge clk_sys);
    endtask

    task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
        wb_q.push_back(e);
        wb_cycle(1'b0, a, 32'h0);
    endtask

    task automatic req(input rmrs_kind_e k, input rmrs_adr_t a,
                       input logic ok, input logic xf,
                       input logic cl = 1'b0);
        ack_q.push_back('{ok, xf, exp_map(a, swap)});
        i_init.send(k, cl, a);
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge link_clk);
    endtask

    // ----------------------------------------------------------
    // Monitor: answers checked against the oldest note
    // ----------------------------------------------------------
    always @(posedge clk_sys) begin
        if (chan_ack.valid === 1'b1 && ack_seen !== 1'b1) cmp_ack();
        ack_seen <= chan_ack.valid;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) cmp_wb();
    end

    task automatic cmp_ack;
        rmrs_exp_s e;
        rmrs_exp_s g;
        e = ack_q.size() > 0 ? ack_q.pop_front() : 'x;
        g = {chan_ack.okay, chan_ack.xfer, mapped_address};
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t ack got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp_wb;
        logic [31:0] e;
        e = wb_q.size() > 0 ? wb_q.pop_front() : 'x;
        n_compared++;
        if (wb_dat_o !== e) begin
            failures++;
            $display("[FAIL] %0t rd got %h exp %h", $time, wb_dat_o, e);
        end
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #500us;
        failures++;
        tally_and_finish();
    end

    initial begin
        ra = '0;
        ra[35:20] = 16'h0012;
        rb = ra;
        rb[35:20] = 16'h0345;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        wb_rd(8'h00, 32'h040A0701);
        wb_rd(8'h04, 32'h00000000);
        wb_rd(8'h0C, 32'h00000000);
        wb_cycle(1'b1, 8'h00, 32'hFFFFFFFF);
        wb_rd(8'h00, 32'h1F1F1F1F);
        wb_cycle(1'b1, 8'h00, 32'h00000000);
        req(K_READ, ra, 1'b0, 1'b0);
        req(K_READ, rb, 1'b0, 1'b0);
        gap(20);
        req(K_READ, ra, 1'b1, 1'b1);
        req(K_WRITE, ra, 1'b1, 1'b1);
        req(K_READ, rb, 1'b0, 1'b0);
        req(K_READ, ra, 1'b0, 1'b0);
        gap(30);
        req(K_READ, rb, 1'b1, 1'b1);
        req(K_REFR, rb, 1'b1, 1'b0);
        wb_rd(8'h08, 32'h0000000E);
        for (int i = 0; i < 7; i++) begin
            rx = rmrs_adr_t'({$random(seed), $random(seed)});
            wb_cycle(1'b1, 8'h04, i == 0 ? 32'h1FF : $random(seed));
            req(K_READ, rx, 1'b0, 1'b0);
        end
        wb_cycle(1'b1, 8'h04, 32'h0);
        gap(140);
        req(K_READ, rb, 1'b1, 1'b1);
        req(K_WRITE, rb, 1'b1, 1'b1, 1'b1);
        req(K_READ, ra, 1'b0, 1'b0);
        gap(30);
        req(K_READ, ra, 1'b1, 1'b1);
        gap(4);
        tally_and_finish();
    end
endmodule
